// ### core/bix_regs.svh
// field positions, opcodes and reset values of the instruction executor
`ifndef BIX_REGS_SVH
`define BIX_REGS_SVH

`define BIX_OP6_FLD   13:8
`define BIX_JP_FLD    13:11
`define BIX_LP_FLD    13:10
`define BIX_K11_FLD   10:0
`define BIX_K8_FLD    7:0
`define BIX_F_FLD     6:0
`define BIX_D_BIT     7
`define BIX_LAT_FLD   4:3
`define BIX_PCH_FLD   12:11
`define BIX_PCL_FLD   10:0

`define BIX_JMP_PFX   3'h5
`define BIX_LDL_PFX   4'hc
`define BIX_DEC_OP    6'h03
`define BIX_INC_OP    6'h0a
`define BIX_DSK_OP    6'h0b
`define BIX_ISK_OP    6'h0f
`define BIX_ORL_OP    6'h38

`define BIX_PC_RST    13'h0000
`define BIX_PC_ONE    13'h0001
`define BIX_ACC_RST   8'h00
`define BIX_NUL_RST   1'h0
`define BIX_ONE8      8'h01
`define BIX_ZERO8     8'h00
`define BIX_D_ACC     1'h0

`endif

// ### core/bix_pkg.sv
// types of the instruction executor
package bix_pkg;

  typedef struct packed {
    logic        valid;
    logic [13:0] word;
  } bix_instr_s;

  typedef struct packed {
    logic        wr;
    logic [6:0]  addr;
    logic [7:0]  data;
  } bix_fwr_s;

  typedef struct packed {
    logic [12:0] pc;
    logic [7:0]  acc;
    logic        null_flag;
  } bix_arch_s;

  typedef enum logic [3:0] {
    OP_OTHER,
    OP_JUMP,
    OP_DEC,
    OP_INC,
    OP_DSKIP,
    OP_ISKIP,
    OP_ORLIT,
    OP_LDLIT
  } bix_op_e;

  typedef enum logic {
    ST_RUN,
    ST_ANNUL
  } bix_st_e;

endpackage

// ### core/bix_exec.sv
// executor for jump, inc/dec (with skip) and literal accumulator ops
// Function
// - jump loads its 11-bit immediate into program counter bits 10..0
// - jump copies latch bits 4..3 into program counter bits 12..11
// - jump takes two instruction cycles and leaves flags unchanged
// - decrement_file subtracts one; destination by target_select; updates null flag
// - increment_file adds one; destination by target_select; updates null flag
// - decrement_skip_on_null decrements to chosen destination, flags untouched
// - zero result discards next instruction as a no-op, two cycles
// - increment_skip_on_null increments likewise, zero result skips next instruction
// - or_literal_into_acc ORs literal into accumulator, updates null flag
// - load_literal_acc loads literal into accumulator, flags unchanged
`timescale 1ns/1ps
`include "bix_regs.svh"

module bix_exec #(
  parameter int FILE_DEPTH = 128,
  parameter int PC_W       = 13
) (
  input  wire logic               clock,        // 20 MHz core clock
  input  wire logic               sys_rst,      // sync reset, active high
  input  wire bix_pkg::bix_instr_s instr,       // instruction word with valid
  output logic                    instr_ready,  // word may be taken
  input  wire logic [7:0]         jump_latch,   // upper_jump_latch contents
  input  wire bix_pkg::bix_fwr_s  file_wr,      // outside file write port
  input  wire logic [6:0]         file_rd_addr, // outside file read address
  output logic [7:0]              file_rd_data, // registered file read data
  output bix_pkg::bix_arch_s      arch,         // pc, accumulator, null flag
  output logic                    retire,       // pulse: word executed
  output logic                    annul         // pulse: word discarded
);

  logic [7:0]      file_mem [FILE_DEPTH];
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [7:0]      acc_r;
  logic [7:0]      acc_nxt;
  logic            null_r;
  logic            null_nxt;
  logic            retire_r;
  logic            annul_r;
  logic [7:0]      rd_r;
  bix_pkg::bix_st_e st_r;
  bix_pkg::bix_st_e st_nxt;
  bix_pkg::bix_op_e op;

  logic            take;
  logic            exec;
  logic [6:0]      faddr;
  logic            dsel;
  logic [7:0]      fval;
  logic [7:0]      inc_val;
  logic [7:0]      dec_val;
  logic [7:0]      or_val;
  logic [7:0]      res;
  logic [7:0]      k8;
  logic [10:0]     k11;
  logic            file_we;
  logic            skip;

  // decode
  always_comb begin
    op = bix_pkg::OP_OTHER;
    if (instr.word[`BIX_JP_FLD] == `BIX_JMP_PFX) begin
      op = bix_pkg::OP_JUMP;
    end else if (instr.word[`BIX_LP_FLD] == `BIX_LDL_PFX) begin
      // don't-care bits ignored; supplier clears them
      op = bix_pkg::OP_LDLIT;
    end else begin
      unique case (instr.word[`BIX_OP6_FLD])
        `BIX_DEC_OP: op = bix_pkg::OP_DEC;
        `BIX_INC_OP: op = bix_pkg::OP_INC;
        `BIX_DSK_OP: op = bix_pkg::OP_DSKIP;
        `BIX_ISK_OP: op = bix_pkg::OP_ISKIP;
        `BIX_ORL_OP: op = bix_pkg::OP_ORLIT;
        default:     op = bix_pkg::OP_OTHER;
      endcase
    end
  end

  assign instr_ready = !sys_rst;
  assign take        = instr.valid && instr_ready;
  assign exec        = take && (st_r == bix_pkg::ST_RUN);
  assign faddr       = instr.word[`BIX_F_FLD];
  assign dsel        = instr.word[`BIX_D_BIT];
  assign k8          = instr.word[`BIX_K8_FLD];
  assign k11         = instr.word[`BIX_K11_FLD];
  assign fval        = file_mem[faddr];
  assign inc_val     = fval + `BIX_ONE8;
  assign dec_val     = fval - `BIX_ONE8;
  assign or_val      = acc_r | k8;

  // result of the file ops
  always_comb begin
    res = fval;
    unique case (op)
      bix_pkg::OP_DEC,
      bix_pkg::OP_DSKIP: res = dec_val;
      bix_pkg::OP_INC,
      bix_pkg::OP_ISKIP: res = inc_val;
      bix_pkg::OP_ORLIT: res = or_val;
      bix_pkg::OP_LDLIT: res = k8;
      bix_pkg::OP_JUMP,
      bix_pkg::OP_OTHER: res = fval;
    endcase
  end

  // skip when the skip variant yields zero
  assign skip = exec && (res == `BIX_ZERO8) &&
                (op == bix_pkg::OP_DSKIP || op == bix_pkg::OP_ISKIP);

  assign file_we = exec && dsel &&
                   (op == bix_pkg::OP_DEC || op == bix_pkg::OP_INC ||
                    op == bix_pkg::OP_DSKIP || op == bix_pkg::OP_ISKIP);

  // sequencing: jump and taken skip annul the following word
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      bix_pkg::ST_RUN: begin
        if ((exec && op == bix_pkg::OP_JUMP) || skip) begin
          st_nxt = bix_pkg::ST_ANNUL;
        end
      end
      bix_pkg::ST_ANNUL: begin
        if (take) begin
          st_nxt = bix_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= bix_pkg::ST_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // program counter
  always_comb begin
    pc_nxt = pc_r;
    if (exec && op == bix_pkg::OP_JUMP) begin
      pc_nxt[`BIX_PCL_FLD] = k11;
      pc_nxt[`BIX_PCH_FLD] = jump_latch[`BIX_LAT_FLD];
    end else if (take) begin
      pc_nxt = pc_r + `BIX_PC_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pc_r <= `BIX_PC_RST;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // accumulator
  always_comb begin
    acc_nxt = acc_r;
    if (exec) begin
      unique case (op)
        bix_pkg::OP_DEC,
        bix_pkg::OP_INC,
        bix_pkg::OP_DSKIP,
        bix_pkg::OP_ISKIP: begin
          if (dsel == `BIX_D_ACC) begin
            acc_nxt = res;
          end
        end
        bix_pkg::OP_ORLIT: acc_nxt = res;
        bix_pkg::OP_LDLIT: acc_nxt = res;
        bix_pkg::OP_JUMP,
        bix_pkg::OP_OTHER: acc_nxt = acc_r;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      acc_r <= `BIX_ACC_RST;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // null flag: only dec, inc and or-literal touch it
  always_comb begin
    null_nxt = null_r;
    if (exec && (op == bix_pkg::OP_DEC || op == bix_pkg::OP_INC ||
                 op == bix_pkg::OP_ORLIT)) begin
      null_nxt = (res == `BIX_ZERO8);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      null_r <= `BIX_NUL_RST;
    end else begin
      null_r <= null_nxt;
    end
  end

  // file registers; executed write wins over outside port
  always_ff @(posedge clock) begin
    if (file_we) begin
      file_mem[faddr] <= res;
    end else if (file_wr.wr) begin
      file_mem[file_wr.addr] <= file_wr.data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_r <= `BIX_ZERO8;
    end else begin
      rd_r <= file_mem[file_rd_addr];
    end
  end

  // retire and annul pulses
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      retire_r <= 1'b0;
      annul_r  <= 1'b0;
    end else begin
      retire_r <= exec;
      annul_r  <= take && (st_r == bix_pkg::ST_ANNUL);
    end
  end

  assign arch.pc        = pc_r;
  assign arch.acc       = acc_r;
  assign arch.null_flag = null_r;
  assign file_rd_data   = rd_r;
  assign retire         = retire_r;
  assign annul          = annul_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_jump;
    exec && op == bix_pkg::OP_JUMP;
  endsequence

  sequence s_skip_hit;
    skip;
  endsequence

  sequence s_annul_next;
    st_r == bix_pkg::ST_ANNUL && instr.valid;
  endsequence

  a_jump_low_pc: assert property (
    s_jump |=> pc_r[`BIX_PCL_FLD] == $past(k11))
    else $error("jump low pc bits wrong");

  a_jump_high_pc: assert property (
    s_jump |=> pc_r[`BIX_PCH_FLD] == $past(jump_latch[`BIX_LAT_FLD]))
    else $error("jump high pc bits wrong");

  a_jump_two_cyc: assert property (
    s_jump ##1 instr.valid |=> annul && !retire && $stable(null_r) && $stable(acc_r))
    else $error("jump did not annul the next word");

  a_jump_flags: assert property (
    s_jump |=> $stable(null_r))
    else $error("jump changed a flag");

  a_dec_dest: assert property (
    exec && op == bix_pkg::OP_DEC |=>
      ($past(dsel) ? file_mem[$past(faddr)] == $past(dec_val)
                   : acc_r == $past(dec_val)))
    else $error("decrement result misplaced");

  a_inc_dest: assert property (
    exec && op == bix_pkg::OP_INC |=>
      ($past(dsel) ? file_mem[$past(faddr)] == $past(inc_val)
                   : acc_r == $past(inc_val)))
    else $error("increment result misplaced");

  a_dskip_quiet: assert property (
    exec && op == bix_pkg::OP_DSKIP |=> $stable(null_r) &&
      ($past(dsel) ? file_mem[$past(faddr)] == $past(dec_val)
                   : acc_r == $past(dec_val)))
    else $error("decrement-skip result or flag wrong");

  a_skip_annul: assert property (
    s_skip_hit ##1 instr.valid |=> annul && !retire)
    else $error("skip did not discard next word");

  a_noskip_run: assert property (
    exec && !skip && op != bix_pkg::OP_JUMP |=> st_r == bix_pkg::ST_RUN)
    else $error("non-zero result skipped");

  a_iskip_quiet: assert property (
    exec && op == bix_pkg::OP_ISKIP |=> $stable(null_r) &&
      (st_r == bix_pkg::ST_ANNUL) == ($past(inc_val) == `BIX_ZERO8))
    else $error("increment-skip flag or skip wrong");

  a_or_literal: assert property (
    exec && op == bix_pkg::OP_ORLIT |=>
      acc_r == ($past(acc_r) | $past(k8)))
    else $error("or literal result wrong");

  a_load_literal: assert property (
    exec && op == bix_pkg::OP_LDLIT |=> acc_r == $past(k8) && $stable(null_r))
    else $error("load literal wrong");

  a_null_flag: assert property (
    exec && (op == bix_pkg::OP_DEC || op == bix_pkg::OP_INC ||
             op == bix_pkg::OP_ORLIT) |=> null_r == ($past(res) == `BIX_ZERO8))
    else $error("null flag wrong");

  a_annul_hold: assert property (
    s_annul_next |=> annul && !retire &&
      $stable(acc_r) && $stable(null_r) && st_r == bix_pkg::ST_RUN)
    else $error("annulled word had an effect");

endmodule

// ### verif/tb_branch_incdec_literal_exec.sv
// self-checking bench of the jump, inc/dec and literal executor
`timescale 1ns/1ps
`include "bix_regs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t %h %h", $time, (a), (b)); end end

module tb_branch_incdec_literal_exec;
  logic                clock;
  logic                sys_rst;
  bix_pkg::bix_instr_s instr;
  logic                instr_ready;
  logic [7:0]          jump_latch;
  bix_pkg::bix_fwr_s   file_wr;
  logic [6:0]          file_rd_addr;
  logic [7:0]          file_rd_data;
  bix_pkg::bix_arch_s  arch;
  logic                retire;
  logic                annul;
  int                  n_errors;
  int                  cmp_count;

  bix_exec u_dut (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .instr        (instr),
    .instr_ready  (instr_ready),
    .jump_latch   (jump_latch),
    .file_wr      (file_wr),
    .file_rd_addr (file_rd_addr),
    .file_rd_data (file_rd_data),
    .arch         (arch),
    .retire       (retire),
    .annul        (annul)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic end_of_test();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cyc();
    @(posedge clock);
    @(negedge clock);
  endtask

  // word stays valid until the next call or an idle
  task automatic ex(input logic [13:0] w);
    instr = {1'b1, w};
    cyc();
  endtask

  task automatic fw(input logic [6:0] a, input logic [7:0] d);
    instr   = '0;
    file_wr = {1'b1, a, d};
    cyc();
    file_wr = '0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    instr        = '0;
    file_rd_addr = a;
    cyc();
    cyc();
    `CHK(file_rd_data, e)
  endtask

  // clear acc and force the null flag high
  task automatic null_hi();
    ex({`BIX_LDL_PFX, 2'h0, 8'h00});
    ex({`BIX_ORL_OP, 8'h00});
  endtask

  task automatic t_literal();
    null_hi();
    `CHK(arch.null_flag, 1'h1)
    ex({`BIX_LDL_PFX, 2'h0, 8'h5a});
    `CHK(arch.acc, 8'h5a)
    `CHK(arch.null_flag, 1'h1)
    ex({`BIX_ORL_OP, 8'h81});
    `CHK(arch.acc, 8'hdb)
    `CHK(arch.null_flag, 1'h0)
    ex({`BIX_LDL_PFX, 2'h0, 8'h00});
    `CHK(arch.null_flag, 1'h0)
    `CHK(retire, 1'h1)
  endtask

  task automatic t_incdec();
    fw(7'h03, 8'h01);
    ex({`BIX_DEC_OP, 1'h1, 7'h03});
    `CHK(arch.null_flag, 1'h1)
    rd(7'h03, 8'h00);
    ex({`BIX_DEC_OP, 1'h0, 7'h03});
    `CHK(arch.acc, 8'hff)
    `CHK(arch.null_flag, 1'h0)
    ex({`BIX_INC_OP, 1'h0, 7'h03});
    `CHK(arch.acc, 8'h01)
    rd(7'h03, 8'h00);
    fw(7'h7f, 8'hff);
    ex({`BIX_INC_OP, 1'h1, 7'h7f});
    `CHK(arch.null_flag, 1'h1)
    `CHK(arch.acc, 8'h01)
    rd(7'h7f, 8'h00);
  endtask

  task automatic t_skip();
    fw(7'h09, 8'h01);
    null_hi();
    ex({`BIX_DSK_OP, 1'h1, 7'h09});
    `CHK(retire, 1'h1)
    `CHK(arch.null_flag, 1'h1)
    ex({`BIX_LDL_PFX, 2'h0, 8'h33});
    `CHK(annul, 1'h1)
    `CHK(arch.acc, 8'h00)
    rd(7'h09, 8'h00);
    ex({`BIX_ISK_OP, 1'h0, 7'h09});
    `CHK(arch.acc, 8'h01)
    `CHK(arch.null_flag, 1'h1)
    ex({`BIX_LDL_PFX, 2'h0, 8'h44});
    `CHK(annul, 1'h0)
    `CHK(arch.acc, 8'h44)
    fw(7'h0a, 8'h02);
    ex({`BIX_DSK_OP, 1'h0, 7'h0a});
    `CHK(arch.acc, 8'h01)
    `CHK(arch.null_flag, 1'h1)
    ex({`BIX_LDL_PFX, 2'h0, 8'h55});
    `CHK(annul, 1'h0)
    `CHK(arch.acc, 8'h55)
    fw(7'h0b, 8'hff);
    ex({`BIX_ISK_OP, 1'h1, 7'h0b});
    // idle cycle: the pending discard waits for a valid word
    instr = '0;
    cyc();
    ex({`BIX_LDL_PFX, 2'h0, 8'h66});
    `CHK(annul, 1'h1)
    `CHK(arch.acc, 8'h55)
    rd(7'h0b, 8'h00);
  endtask

  task automatic t_jump();
    logic [7:0]  lat [2];
    logic [10:0] k [2];
    logic [12:0] e;
    lat = '{8'h0f, 8'hf7};
    k   = '{11'h5a3, 11'h7ff};
    for (int i = 0; i < 2; i++) begin
      null_hi();
      jump_latch = lat[i];
      e          = {lat[i][4:3], k[i]};
      ex({`BIX_JMP_PFX, k[i]});
      `CHK(arch.pc, e)
      `CHK(arch.null_flag, 1'h1)
      ex({`BIX_LDL_PFX, 2'h0, 8'h77});
      `CHK(annul, 1'h1)
      `CHK(arch.pc, e + 13'h0001)
      `CHK(arch.acc, 8'h00)
      // undecoded word: only the program counter moves
      ex(14'h0000);
      `CHK(arch.pc, e + 13'h0002)
      `CHK(retire, 1'h1)
      `CHK(annul, 1'h0)
      `CHK(arch.acc, 8'h00)
    end
  endtask

  // reset while a discard is pending clears it
  task automatic t_reset_mid();
    ex({`BIX_JMP_PFX, 11'h123});
    instr   = '0;
    sys_rst = 1'b1;
    cyc();
    cyc();
    `CHK(instr_ready, 1'h0)
    `CHK(arch, '0)
    `CHK(annul, 1'h0)
    sys_rst = 1'b0;
    ex({`BIX_LDL_PFX, 2'h0, 8'h12});
    `CHK(annul, 1'h0)
    `CHK(retire, 1'h1)
    `CHK(arch.acc, 8'h12)
  endtask

  initial begin
    cyc();
    end_of_test_guard: begin
      repeat (5000) @(posedge clock);
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    n_errors     = 0;
    cmp_count    = 0;
    sys_rst      = 1'b1;
    instr        = '0;
    jump_latch   = 8'h00;
    file_wr      = '0;
    file_rd_addr = 7'h00;
    repeat (6) @(negedge clock);
    `CHK(instr_ready, 1'h0)
    `CHK(arch, '0)
    sys_rst = 1'b0;
    cyc();
    `CHK(instr_ready, 1'h1)
    t_literal();
    t_incdec();
    t_skip();
    t_jump();
    t_reset_mid();
    end_of_test();
  end
endmodule
